// [core/mrrs_pkg.sv]
// Constants and carriers shared by the memory remap and reset-source block.
package mrrs_pkg;

    // ------------------------------------------------------------------
    // Address map.
    // ------------------------------------------------------------------
    localparam logic [31:0] MRRS_SRAM_BASE   = 32'h0004_0000; // SRAM array base.
    localparam int          MRRS_SRAM_WORDS  = 1536;          // 32-bit words of SRAM.
    localparam logic [31:0] MRRS_SRAM_BYTES  = 32'h0000_1800; // SRAM span in bytes.
    localparam logic [31:0] MRRS_LOW_SIZE    = 32'h0001_8000; // 96 kB remap window.
    localparam logic [31:0] MRRS_VECTOR_TOP  = 32'h0000_0020; // Last exception vector.
    localparam logic [31:0] MRRS_NVM_BASE    = 32'h0008_0000; // Absolute NVM base.
    localparam logic [31:0] MRRS_NVM_BYTES   = 32'h0001_8000; // NVM span in bytes.
    localparam logic [31:0] MRRS_REMAP_ADDR  = 32'hFFFF_0220; // low_memory_remap.
    localparam logic [31:0] MRRS_FLAGS_ADDR  = 32'hFFFF_0230; // reset_source_flags.
    localparam logic [31:0] MRRS_CLEAR_ADDR  = 32'hFFFF_0234; // reset_flag_clear.

    // ------------------------------------------------------------------
    // Field positions and values after reset.
    // ------------------------------------------------------------------
    localparam int          MRRS_REMAP_BIT   = 0;     // Remap select bit.
    localparam int          MRRS_POR_BIT     = 0;     // Power-on flag.
    localparam int          MRRS_WDOG_BIT    = 1;     // Watchdog flag.
    localparam int          MRRS_SW_BIT      = 2;     // Software reset flag.
    localparam int          MRRS_EXT_BIT     = 3;     // External pin flag.
    localparam logic        MRRS_REMAP_RESET = 1'b0;  // NVM at address zero.
    localparam logic [3:0]  MRRS_FLAGS_RESET = 4'h1;  // Power-on flag only.
    localparam logic [1:0]  MRRS_SIZE_BYTE   = 2'h0;  // Byte access.
    localparam logic [1:0]  MRRS_SIZE_HALF   = 2'h1;  // Halfword access.
    localparam logic [1:0]  MRRS_SIZE_WORD   = 2'h2;  // Word access.

    // ------------------------------------------------------------------
    // Timing: reset hold rounded up to whole cycles.
    // ------------------------------------------------------------------
    localparam int MRRS_CLK_NS      = 25;   // ref_clk period.
    localparam int MRRS_RST_HOLD_NS = 200;  // Least system reset width.
    localparam int MRRS_RST_CYCLES  = (MRRS_RST_HOLD_NS + MRRS_CLK_NS - 1) / MRRS_CLK_NS;

    // Sequencer phases.
    typedef enum logic [1:0] {
        MRRS_PH_RESET,
        MRRS_PH_KERNEL,
        MRRS_PH_RUN
    } mrrs_phase_e;

    // Bus or memory request.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mrrs_req_s;

    // Bus or memory answer.
    typedef struct packed {
        logic        valid;
        logic        abort;
        logic [31:0] rdata;
    } mrrs_rsp_s;

    // Whole state of the top module.
    typedef struct packed {
        mrrs_phase_e phase;
        logic [3:0]  hold_cnt;
        logic        por_pending;
        logic        remap;
        logic [3:0]  flags;
        logic        ram_valid;
        logic [1:0]  ext_sync;
        logic        sram_rd;
        mrrs_rsp_s   rsp;
        mrrs_req_s   nvm_req;
    } mrrs_state_s;

    // State after power-on reset.
    localparam mrrs_state_s MRRS_STATE_RESET = '{
        phase: MRRS_PH_RESET, hold_cnt: 4'h0, por_pending: 1'b1,
        remap: MRRS_REMAP_RESET, flags: MRRS_FLAGS_RESET, ram_valid: 1'b0,
        ext_sync: 2'h3, sram_rd: 1'b0, rsp: '0, nvm_req: '0};

endpackage

// [core/mrrs_sram.sv]
// Word-wide user SRAM with byte lanes and registered read data.
`timescale 1ns/1ps
`default_nettype none
module mrrs_sram #(
    parameter int WORDS = mrrs_pkg::MRRS_SRAM_WORDS  // Depth in 32-bit words.
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    input  wire logic                     en,
    input  wire logic                     we,
    input  wire logic [3:0]               be,
    input  wire logic [$clog2(WORDS)-1:0] index,
    input  wire logic [31:0]              wdata,
    output logic      [31:0]              rdata
);
    import mrrs_pkg::*;

    // Depth below two leaves no address bit to decode.
    if (WORDS < 2) begin : g_bad_depth
        $error("mrrs_sram: WORDS must be at least 2.");
    end

    logic [31:0] mem [WORDS];  // Array has no reset, so contents survive resets.

    // Byte-lane writes; each lane only touches its own eight bits.
    always_ff @(posedge ref_clk) begin
        if (en && we) begin
            for (int b = 0; b < 4; b++) begin
                if (be[b]) begin
                    mem[index][8*b +: 8] <= wdata[8*b +: 8];
                end
            end
        end
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
        end else if (en && !we) begin
            rdata <= mem[index];
        end
    end

endmodule // mrrs_sram
`default_nettype wire

// [core/mrrs_top.sv]
// Low memory remap decoder and reset-source recorder with reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module mrrs_top (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire mrrs_pkg::mrrs_req_s bus_req,
    output logic                     bus_ready,
    output mrrs_pkg::mrrs_rsp_s      bus_rsp,
    output mrrs_pkg::mrrs_req_s      nvm_req,
    input  wire mrrs_pkg::mrrs_rsp_s nvm_rsp,
    input  wire logic                wdog_timeout,
    input  wire logic                ext_rst_n_pin,
    input  wire logic                kernel_done,
    input  wire logic                download_reset,
    input  wire logic                low_voltage_flag_en,
    input  wire logic                low_voltage_flag,
    output logic                     sys_reset,
    output logic                     kernel_run,
    output logic                     remap_sram,
    output logic                     ram_valid
);
    import mrrs_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks.
    // ------------------------------------------------------------------

    // The hold counter is four bits wide.
    if (MRRS_RST_CYCLES < 1 || MRRS_RST_CYCLES > 15) begin : g_bad_hold
        $error("mrrs_top: reset hold must be 1 to 15 cycles.");
    end

    // Last count of the hold phase.
    localparam logic [3:0] RST_LAST = 4'(MRRS_RST_CYCLES - 1);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    mrrs_state_s r;           // Registered state.
    mrrs_state_s next_r;      // Next state.
    logic        accept;      // Request taken this cycle.
    logic        aligned;     // Access is naturally aligned.
    logic        in_low;      // Address inside the remap window.
    logic        in_sram;     // Address inside absolute SRAM.
    logic        in_nvm;      // Address inside absolute NVM.
    logic        sram_hit;    // Access goes to SRAM.
    logic        nvm_hit;     // Access goes to NVM.
    logic        remap_hit;   // Access to low_memory_remap.
    logic        flags_hit;   // Access to reset_source_flags.
    logic        clear_hit;   // Access to reset_flag_clear.
    logic [3:0]  lane_be;     // Byte enables of the access.
    logic [31:0] sram_rdata;  // Registered SRAM read data.
    logic        wdog_evt;    // Watchdog reset event.
    logic        ext_evt;     // External pin reset event.
    logic        sw_evt;      // Software reset event.
    logic        any_evt;     // Any non-power-on reset event.
    logic [3:0]  set_mask;    // Flags set this cycle.
    logic [3:0]  clr_mask;    // Flags cleared this cycle.

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------

    // Requests are refused during reset hold and while NVM is busy.
    assign bus_ready = (r.phase != MRRS_PH_RESET) && !r.nvm_req.valid;
    assign accept    = bus_req.valid && bus_ready;

    // Misaligned halfwords and words are treated as unmapped.
    assign aligned = (bus_req.size == MRRS_SIZE_BYTE)
                  || (bus_req.size == MRRS_SIZE_HALF && !bus_req.addr[0])
                  || (bus_req.size == MRRS_SIZE_WORD && bus_req.addr[1:0] == 2'h0);

    // 96 kB window holding the vectors.
    assign in_low  = bus_req.addr < MRRS_LOW_SIZE;
    assign in_sram = (bus_req.addr >= MRRS_SRAM_BASE)
                  && (bus_req.addr < MRRS_SRAM_BASE + MRRS_SRAM_BYTES);
    assign in_nvm  = (bus_req.addr >= MRRS_NVM_BASE)
                  && (bus_req.addr < MRRS_NVM_BASE + MRRS_NVM_BYTES);

    // Remap selects SRAM in the window.
    // SRAM is smaller than the window; the rest of it aborts while remapped.
    assign sram_hit = aligned && (in_sram
                   || (in_low && r.remap && bus_req.addr < MRRS_SRAM_BYTES));
    // Without remap the window shows NVM.
    assign nvm_hit  = aligned && (in_nvm || (in_low && !r.remap));

    // Registers answer only at their exact word address.
    assign remap_hit = aligned && (bus_req.addr == MRRS_REMAP_ADDR);
    assign flags_hit = aligned && (bus_req.addr == MRRS_FLAGS_ADDR);
    assign clear_hit = aligned && (bus_req.addr == MRRS_CLEAR_ADDR);

    // Byte enables for each access size.
    always_comb begin
        case (bus_req.size)
            MRRS_SIZE_BYTE: lane_be = 4'h1 << bus_req.addr[1:0];
            MRRS_SIZE_HALF: lane_be = bus_req.addr[1] ? 4'hC : 4'h3;
            default:        lane_be = 4'hF;
        endcase
    end

    // ------------------------------------------------------------------
    // SRAM instance.
    // ------------------------------------------------------------------

    // Index bits 12:2 serve both the absolute and the remapped view.
    mrrs_sram #(
        .WORDS (MRRS_SRAM_WORDS)
    ) u_sram (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .en      (accept && sram_hit && !any_evt),
        .we      (bus_req.write),
        .be      (lane_be),
        .index   (bus_req.addr[12:2]),
        .wdata   (bus_req.wdata),
        .rdata   (sram_rdata)
    );

    // ------------------------------------------------------------------
    // Reset events.
    // ------------------------------------------------------------------

    // The watchdog is on this clock; the pin passed two flip-flops.
    assign wdog_evt = wdog_timeout;
    assign ext_evt  = !r.ext_sync[1];
    assign any_evt  = wdog_evt || ext_evt || sw_evt;

    // Each source sets only its own flag.
    always_comb begin
        set_mask                = 4'h0;
        set_mask[MRRS_WDOG_BIT] = wdog_evt;
        set_mask[MRRS_SW_BIT]   = sw_evt;
        set_mask[MRRS_EXT_BIT]  = ext_evt;
    end

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------

    // Bus access, flag update and reset sequencing in one pass.
    always_comb begin
        next_r          = r;
        next_r.rsp      = '0;
        next_r.sram_rd  = 1'b0;
        next_r.ext_sync = {r.ext_sync[0], ext_rst_n_pin};
        sw_evt          = 1'b0;
        clr_mask        = 4'h0;

        // Register accesses answer one cycle after acceptance.
        if (accept) begin
            if (sram_hit) begin
                // SRAM data comes straight from the memory's register.
                next_r.rsp.valid = 1'b1;
                next_r.sram_rd   = !bus_req.write;
            end else if (nvm_hit) begin
                // NVM sees an offset from its own base.
                next_r.nvm_req       = bus_req;
                next_r.nvm_req.valid = 1'b1;
                if (in_nvm) begin
                    next_r.nvm_req.addr = bus_req.addr - MRRS_NVM_BASE;
                end
            end else if (remap_hit) begin
                next_r.rsp.valid = 1'b1;
                if (bus_req.write) begin
                    next_r.remap = bus_req.wdata[MRRS_REMAP_BIT];
                end else begin
                    // Reserved remap bits read as zero.
                    next_r.rsp.rdata = {31'h0000_0000, r.remap};
                end
            end else if (flags_hit) begin
                next_r.rsp.valid = 1'b1;
                if (bus_req.write) begin
                    // Writing bit 2 starts a software reset.
                    sw_evt = bus_req.wdata[MRRS_SW_BIT];
                end else begin
                    next_r.rsp.rdata = {28'h000_0000, r.flags};
                end
            end else if (clear_hit) begin
                // Reads return zero and change nothing.
                next_r.rsp.valid = 1'b1;
                if (bus_req.write) begin
                    clr_mask = bus_req.wdata[3:0];
                    // Keeping bit 2 set resets again.
                    sw_evt = r.flags[MRRS_SW_BIT] && !bus_req.wdata[MRRS_SW_BIT];
                end
            end else begin
                next_r.rsp.valid = 1'b1;
                next_r.rsp.abort = 1'b1;
            end
        end

        // NVM answer is forwarded one cycle after its acknowledge.
        if (r.nvm_req.valid && nvm_rsp.valid) begin
            next_r.nvm_req = '0;
            next_r.rsp     = nvm_rsp;
        end

        // Set wins over a clear in the same cycle.
        next_r.flags = (r.flags & ~clr_mask) | set_mask;

        // Reset sequencer.
        case (r.phase)
            MRRS_PH_RESET: begin
                // Remap stays clear while reset holds.
                next_r.remap = MRRS_REMAP_RESET;
                if (r.hold_cnt == RST_LAST) begin
                    next_r.phase = MRRS_PH_KERNEL;
                    if (r.por_pending) begin
                        // Low-voltage flag tells SRAM survived power-on.
                        next_r.ram_valid   = low_voltage_flag_en && low_voltage_flag;
                        next_r.por_pending = 1'b0;
                    end
                end else begin
                    next_r.hold_cnt = r.hold_cnt + 4'h1;
                end
            end
            MRRS_PH_KERNEL: begin
                // Boot from the reset vector afterwards.
                if (kernel_done) begin
                    next_r.phase = MRRS_PH_RUN;
                end
            end
            MRRS_PH_RUN: begin
                // Normal operation; nothing to sequence.
                next_r.phase = MRRS_PH_RUN;
            end
            default: begin
                next_r.phase = MRRS_PH_RESET;
            end
        endcase

        // Any reset restarts the sequencer, remap and bus state, not the flags.
        if (any_evt) begin
            next_r.phase    = MRRS_PH_RESET;
            next_r.hold_cnt = 4'h0;
            next_r.remap    = MRRS_REMAP_RESET;
            next_r.nvm_req  = '0;
            next_r.rsp      = '0;
            next_r.sram_rd  = 1'b0;
            // SRAM survives unless a download preceded.
            next_r.ram_valid = r.ram_valid && !download_reset;
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= MRRS_STATE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign bus_rsp.valid = r.rsp.valid;
    assign bus_rsp.abort = r.rsp.abort;
    assign bus_rsp.rdata = r.sram_rd ? sram_rdata : r.rsp.rdata;
    assign nvm_req       = r.nvm_req;
    // System reset for pins, peripherals and registers.
    assign sys_reset     = (r.phase == MRRS_PH_RESET);
    assign kernel_run    = (r.phase == MRRS_PH_KERNEL);
    assign remap_sram    = r.remap;
    assign ram_valid     = r.ram_valid;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------

    // Reset hold lasts the full count.
    sequence s_hold;
        sys_reset [*8];
    endsequence

    // Configuration phase follows with NVM at zero.
    sequence s_boot;
        kernel_run && !remap_sram;
    endsequence

    a_reset_hold_min: assert property (
        @(posedge ref_clk) disable iff (!rstn) $rose(sys_reset) |-> s_hold)
        else $error("System reset released too early.");

    a_kernel_after_reset: assert property (
        @(posedge ref_clk) disable iff (!rstn) $fell(sys_reset) |-> s_boot)
        else $error("Configuration phase did not follow reset.");

    a_remap_in_reset: assert property (
        @(posedge ref_clk) disable iff (!rstn) sys_reset |-> !remap_sram)
        else $error("Remap set during reset.");

    a_por_flag_value: assert property (
        @(posedge ref_clk) disable iff (!rstn) $rose(rstn) |-> r.flags == MRRS_FLAGS_RESET)
        else $error("Flags not 0x01 after power-on.");

    a_wdog_flag_set: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        wdog_timeout |=> r.flags[MRRS_WDOG_BIT] && sys_reset)
        else $error("Watchdog did not set its flag.");

    a_ext_flag_set: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $fell(r.ext_sync[1]) |=> r.flags[MRRS_EXT_BIT] && sys_reset)
        else $error("External pin did not set its flag.");

    a_sw_reset_start: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && flags_hit && bus_req.write && bus_req.wdata[MRRS_SW_BIT]
        |=> r.flags[MRRS_SW_BIT] && sys_reset ##8 !sys_reset || ext_evt)
        else $error("Software reset not started.");

    a_clear_por_flag: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && clear_hit && bus_req.write && bus_req.wdata[MRRS_POR_BIT]
        |=> !r.flags[MRRS_POR_BIT])
        else $error("Clear did not clear flag bit 0.");

    a_clear_retrigger: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && clear_hit && bus_req.write && r.flags[MRRS_SW_BIT]
        && !bus_req.wdata[MRRS_SW_BIT] |=> sys_reset && r.flags[MRRS_SW_BIT])
        else $error("Clear write kept bit 2 without reset.");

    a_flags_read: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && flags_hit && !bus_req.write && !any_evt
        |=> bus_rsp.valid && bus_rsp.rdata == {28'h000_0000, $past(r.flags)})
        else $error("Flag read wrong or upper bits set.");

    a_clear_read_zero: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && clear_hit && !bus_req.write && !any_evt
        |=> bus_rsp.valid && bus_rsp.rdata == 32'h0000_0000 && $stable(r.flags))
        else $error("Clear register read not zero.");

    a_unmapped_abort: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && !any_evt && !sram_hit && !nvm_hit && !remap_hit && !flags_hit
        && !clear_hit |=> bus_rsp.valid && bus_rsp.abort)
        else $error("Unmapped access did not abort.");

    a_low_to_nvm: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && aligned && !any_evt && !r.remap && bus_req.addr <= MRRS_VECTOR_TOP
        |=> nvm_req.valid && nvm_req.addr == $past(bus_req.addr))
        else $error("Low address did not reach NVM.");

    a_remap_to_sram: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        accept && remap_hit && bus_req.write && bus_req.wdata[0] && !any_evt
        |=> remap_sram)
        else $error("Remap write did not select SRAM.");

endmodule // mrrs_top
`default_nettype wire

// [verif/test_mrrs_top.sv]
// Self-checking bench for the memory remap and reset-source block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_mrrs_top;
import mrrs_pkg::*;
logic        ref_clk = 0, rstn = 0, wdg = 0, pin_n = 1, kd = 0, ab, dl = 0, lv = 1;
mrrs_req_s   req = '0, nreq;
mrrs_rsp_s   nrsp = '0, rsp;
logic        rdy, srst, krun, rmp, rv;
logic [31:0] rd, v, a, d;
logic [1:0]  s, o;
int          error_cnt = 0, tests_run = 0;
always #12.5 ref_clk = ~ref_clk;
// The NVM side acknowledges one cycle late and returns the inverted offset.
always @(posedge ref_clk) begin
    nrsp <= (nreq.valid && !nrsp.valid) ? mrrs_rsp_s'{1'b1, 1'b0, ~nreq.addr} : '0;
    kd   <= #1 krun;
end
mrrs_top DUT (.ref_clk(ref_clk), .rstn(rstn), .bus_req(req), .bus_ready(rdy),
    .bus_rsp(rsp), .nvm_req(nreq), .nvm_rsp(nrsp), .wdog_timeout(wdg),
    .ext_rst_n_pin(pin_n), .kernel_done(kd), .download_reset(dl),
    .low_voltage_flag_en(1'b1), .low_voltage_flag(lv), .sys_reset(srst),
    .kernel_run(krun), .remap_sram(rmp), .ram_valid(rv));
// Merges a partial write into the old word on its byte lanes.
function logic [31:0] merge(input logic [1:0] sz, off, input logic [31:0] old, nw);
    logic [31:0] m;
    m = sz == 2'h2 ? 32'hFFFFFFFF : (sz == 2'h1 ? 32'hFFFF : 32'hFF) << (8 * off);
    return (old & ~m) | (nw & m);
endfunction
task conclude;
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
// One bus cycle: hold until taken, then wait for the answer unless none comes.
task xfer(input logic w, input logic [1:0] sz, input logic [31:0] ad, dt, input logic nr = 0);
    int n;
    n = 0;
    @(posedge ref_clk) #1 req = '{1'b1, w, sz, ad, dt};
    while (!rdy && n < 50) begin @(posedge ref_clk) #1 n++; end
    @(posedge ref_clk) #1 req.valid = 1'b0;
    while (!nr && !rsp.valid && n < 50) begin @(posedge ref_clk) #1 n++; end
    rd = rsp.rdata;
    ab = rsp.abort;
    if (n >= 50) error_cnt++;
endtask
// Waits out a reset hold and checks the state that follows it.
task settle;
    int n;
    n = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    while (srst && n < 200) begin @(posedge ref_clk) #1 n++; end
    `CHK(krun, 1'b1)
    `CHK(rmp, 1'b0)
    if (n >= 200) error_cnt++;
endtask
initial begin
    #100us;
    error_cnt++;
    conclude;
end
initial begin
    v = $urandom(49705);
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    settle;
    `CHK(rv, 1'b1)
    xfer(0, 2, 32'hFFFF0230, 0); `CHK(rd, 32'h1)
    xfer(0, 2, 32'hFFFF0234, 0); `CHK(rd, 32'h0)
    xfer(0, 2, 32'h00020000, 0); `CHK(ab, 1'b1)
    for (int i = 0; i < 8; i++) begin
        a = i == 0 ? 32'h000417FC : 32'h40000 + ($urandom % 1536) * 4;
        s = $urandom % 3;
        o = s == 2'h2 ? 2'h0 : (s == 2'h1 ? ($urandom % 2) * 2 : $urandom % 4);
        v = $urandom;
        d = $urandom;
        xfer(1, 2, a, v);
        xfer(1, s, a + o, d);
        xfer(0, 2, a, 0); `CHK(rd, merge(s, o, v, d))
    end
    v = $urandom;
    xfer(1, 2, 32'h00040020, v);
    // Reserved bits written zero; address 0x20 now reads the word written to absolute SRAM.
    xfer(1, 0, 32'hFFFF0220, 1);
    xfer(0, 2, 32'h00000020, 0); `CHK(rd, v)
    xfer(0, 2, 32'hFFFF0220, 0); `CHK(rd, 32'h1)
    @(posedge ref_clk) #1 wdg = 1'b1;
    @(posedge ref_clk) #1 wdg = 1'b0;
    settle;
    xfer(0, 2, 32'h00040020, 0); `CHK(rd, v)
    xfer(0, 2, 32'h00000020, 0); `CHK(rd, ~32'h20)
    xfer(0, 2, 32'h00080004, 0); `CHK(rd, ~32'h4)
    xfer(0, 2, 32'hFFFF0230, 0); `CHK(rd, 32'h3)
    xfer(1, 2, 32'hFFFF0234, 32'h3);
    xfer(0, 2, 32'hFFFF0230, 0); `CHK(rd, 32'h0)
    @(posedge ref_clk) #1 pin_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 pin_n = 1'b1;
    settle;
    xfer(0, 2, 32'hFFFF0230, 0); `CHK(rd, 32'h8)
    xfer(1, 2, 32'hFFFF0230, 32'h4, 1);
    settle;
    xfer(0, 2, 32'hFFFF0230, 0); `CHK(rd, 32'hC)
    xfer(1, 2, 32'hFFFF0234, 32'h8, 1); `CHK(srst, 1'b1)
    settle;
    xfer(1, 2, 32'hFFFF0234, 32'h4); `CHK(srst, 1'b0)
    xfer(0, 2, 32'hFFFF0230, 0); `CHK(rd, 32'h0)
    `CHK(rv, 1'b1)
    @(posedge ref_clk) #1 wdg = 1'b1;
    dl = 1'b1;
    @(posedge ref_clk) #1 wdg = 1'b0;
    dl = 1'b0;
    settle;
    `CHK(rv, 1'b0)
    @(posedge ref_clk) #1 rstn = 1'b0;
    lv = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    settle;
    `CHK(rv, 1'b0)
    xfer(0, 2, 32'hFFFF0230, 0); `CHK(rd, 32'h1)
    conclude;
end
endmodule // test_mrrs_top
`default_nettype wire
